/* swb_pkg.sv */
/*
  swb_pkg: constants shared by the static memory controller and its array.
  assumes: little-endian byte lanes, 32-bit word data bus.
*/
package swb_pkg;
  localparam int          SWB_MEM_BYTES  = 16384;             // array size in bytes
  localparam int          SWB_DATA_W     = 32;
  localparam int          SWB_LANES      = 4;
  localparam int          SWB_ADDR_W     = 14;                // byte address width
  localparam int          SWB_WORD_AW    = 12;                // word index width
  localparam int          SWB_WORDS      = SWB_MEM_BYTES / SWB_LANES;
  localparam logic [1:0]  SWB_SIZE_BYTE  = 2'h0;
  localparam logic [1:0]  SWB_SIZE_HALF  = 2'h1;
  localparam logic [1:0]  SWB_SIZE_WORD  = 2'h2;
  localparam logic [3:0]  SWB_BE_NONE    = 4'h0;
  localparam logic [31:0] SWB_DATA_RESET = 32'h0000_0000;
endpackage

/* swb_array.sv */
/*
  swb_array: word-wide static array with per-lane write enables.
  assumes: one clock; read data is registered, one cycle after the address.
*/
`timescale 1ns/100ps
module swb_array
  import swb_pkg::*;
#(
  parameter int WORDS = SWB_WORDS,
  parameter int AW    = SWB_WORD_AW
) (
  // clock
  input  wire logic                  clock,
  // write port
  input  wire logic [AW-1:0]         wr_index,
  input  wire logic [SWB_LANES-1:0]  wr_lanes,
  input  wire logic [SWB_DATA_W-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]         rd_index,
  output logic      [SWB_DATA_W-1:0] rd_data
);
  logic [SWB_DATA_W-1:0] mem [WORDS];

  // per-lane write, registered read
  always_ff @(posedge clock) begin
    for (int i = 0; i < SWB_LANES; i++) begin
      if (wr_lanes[i]) begin
        mem[wr_index][i*8 +: 8] <= wr_data[i*8 +: 8];
      end
    end
    rd_data <= mem[rd_index];
  end
endmodule

/* swb_ctrl.sv */
/*
  swb_ctrl: static memory controller with a one-entry write-back buffer.
  assumes: core issues at most one request per cycle; writes never stall;
  reads answer two cycles later with rd_valid.
*/
// Functional notes
// - A 16 kB array serves both instruction fetches and data.
// - Byte, halfword and word reads and writes are taken; sub-word writes touch only their lanes.
// - Every write is absorbed at once by the buffer, so writes never wait.
// - The buffer always holds address, data and lanes of the newest write, replacing the old one.
// - Buffered data reaches the array only when a later write arrives, never on reads or idle.
// - Reset discards a buffered write, leaving the array's older contents, unless a write requested at the first reset edge commits it.
`timescale 1ns/100ps
module swb_ctrl
  import swb_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // request from the core
  input  wire logic                  req,
  input  wire logic                  req_write,
  input  wire logic [1:0]            req_size,
  input  wire logic [SWB_ADDR_W-1:0] req_addr,
  input  wire logic [SWB_DATA_W-1:0] req_wdata,
  // answer to the core
  output logic                       ready,
  output logic                       rd_valid,
  output logic      [SWB_DATA_W-1:0] rd_data,
  // buffer state
  output logic                       buf_pending
);
  typedef struct packed {
    logic                   pend;
    logic [SWB_WORD_AW-1:0] index;
    logic [SWB_LANES-1:0]   lanes;
    logic [SWB_DATA_W-1:0]  data;
    logic                   rd_pend;
    logic [SWB_LANES-1:0]   rd_hit_lanes;
    logic [SWB_DATA_W-1:0]  rd_hit_data;
    logic                   rd_valid;
    logic [SWB_DATA_W-1:0]  rd_data;
  } swb_state_t;

  swb_state_t             st_q;
  swb_state_t             st_d;
  logic [SWB_LANES-1:0]   req_lanes;
  logic [SWB_DATA_W-1:0]  req_lane_data;
  logic [SWB_DATA_W-1:0]  arr_rdata;
  logic [SWB_LANES-1:0]   commit_lanes;
  logic [SWB_WORD_AW-1:0] req_index;
  logic [SWB_DATA_W-1:0]  merged;

  assign req_index = req_addr[SWB_ADDR_W-1:2];

  // lane mask and lane-replicated data from size and low address bits
  always_comb begin
    req_lanes     = SWB_BE_NONE;
    req_lane_data = req_wdata;
    unique case (req_size)
      SWB_SIZE_BYTE: begin
        req_lanes     = 4'h1 << req_addr[1:0];
        req_lane_data = {4{req_wdata[7:0]}};
      end
      SWB_SIZE_HALF: begin
        req_lanes     = req_addr[1] ? 4'hC : 4'h3;
        req_lane_data = {2{req_wdata[15:0]}};
      end
      default: begin
        req_lanes     = 4'hF;
        req_lane_data = req_wdata;
      end
    endcase
  end

  // old entry goes to the array only when a new write is requested, even while rst is high
  assign commit_lanes = (req && req_write && st_q.pend) ? st_q.lanes : SWB_BE_NONE;

  swb_array #(
    .WORDS (SWB_WORDS),
    .AW    (SWB_WORD_AW)
  ) u_array (
    .clock    (clock),
    .wr_index (st_q.index),
    .wr_lanes (commit_lanes),
    .wr_data  (st_q.data),
    .rd_index (req_index),
    .rd_data  (arr_rdata)
  );

  // buffered lanes laid over the array word for a read that hit
  always_comb begin
    merged = arr_rdata;
    for (int i = 0; i < SWB_LANES; i++) begin
      if (st_q.rd_hit_lanes[i]) begin
        merged[i*8 +: 8] = st_q.rd_hit_data[i*8 +: 8];
      end
    end
  end

  // next state
  always_comb begin
    st_d          = st_q;
    st_d.rd_valid = st_q.rd_pend;
    st_d.rd_pend  = 1'b0;
    if (st_q.rd_pend) begin
      st_d.rd_data = merged;
    end
    if (req && req_write) begin
      st_d.pend  = 1'b1;
      st_d.index = req_index;
      st_d.lanes = req_lanes;
      st_d.data  = req_lane_data;
    end else if (req) begin
      st_d.rd_pend      = 1'b1;
      st_d.rd_hit_lanes = (st_q.pend && st_q.index == req_index) ? st_q.lanes : SWB_BE_NONE;
      st_d.rd_hit_data  = st_q.data;
    end
    if (rst) begin
      st_d = '0;
      st_d.data    = SWB_DATA_RESET;
      st_d.rd_data = SWB_DATA_RESET;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  assign ready       = !rst;
  assign rd_valid    = st_q.rd_valid;
  assign rd_data     = st_q.rd_data;
  assign buf_pending = st_q.pend;
endmodule

/* swb_ctrl_assertions.sv */
/* swb_ctrl_assertions: port timing checks for swb_ctrl.
   assumes: bound into swb_ctrl; rst is synchronous, active high. */
`timescale 1ns/100ps
module swb_ctrl_assertions
  import swb_pkg::*;
(
  // watched ports
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  req,
  input wire logic                  req_write,
  input wire logic                  ready,
  input wire logic                  rd_valid,
  input wire logic [SWB_DATA_W-1:0] rd_data,
  input wire logic                  buf_pending
);
  logic rd_req;
  logic wr_req;
  // request kinds as the controller takes them
  assign rd_req = req & ~req_write;
  assign wr_req = req & req_write;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_ready_out: assert property (@(posedge clock) disable iff (1'b0) ready == !rst)
    else $error("ready wrong");
  a_read_lat: assert property (rd_req |-> ##2 rd_valid) else $error("read late");
  a_valid_src: assert property (rd_valid |-> $past(rd_req, 2)) else $error("stray valid");
  a_data_hold: assert property (!rd_valid |-> $stable(rd_data)) else $error("data moved");
  a_wr_pend: assert property (wr_req |=> buf_pending) else $error("write lost");
  a_pend_keep: assert property (buf_pending |=> buf_pending) else $error("pend dropped");
  a_pend_src: assert property ($rose(buf_pending) |-> $past(wr_req)) else $error("pend src");
  a_rst_clear: assert property (@(posedge clock) disable iff (1'b0)
    rst |=> !buf_pending && !rd_valid) else $error("reset kept");
endmodule
bind swb_ctrl swb_ctrl_assertions chk_i (.clock, .rst, .req, .req_write, .ready, .rd_valid,
  .rd_data, .buf_pending);

/* swb_core_model.sv */
/* swb_core_model: core side, one request per call, back to back.
   assumes: tasks are entered just after a rising edge. */
`timescale 1ns/100ps
module swb_core_model
  import swb_pkg::*;
(
  // request lines
  input  wire logic                  clock,
  output logic                       req,
  output logic                       req_write,
  output logic      [1:0]            req_size,
  output logic      [SWB_ADDR_W-1:0] req_addr,
  output logic      [SWB_DATA_W-1:0] req_wdata
);
  // quiet bus at time zero
  initial begin
    req       = 1'b0;
    req_write = 1'b0;
    req_size  = 2'h0;
    req_addr  = 14'h0000;
    req_wdata = 32'h0000_0000;
  end
  // one request held over one edge
  task automatic issue(input logic w, input logic [1:0] s, input logic [13:0] a,
                       input logic [31:0] d);
    {req, req_write, req_size, req_addr, req_wdata} = {1'b1, w, s, a, d};
    @(posedge clock) #1;
  endtask
  // released lines drop req and show the inverse of req_write, req_addr and req_wdata; req_size keeps its stale value
  task automatic idle();
    {req, req_write, req_addr, req_wdata} = {1'b0, ~req_write, ~req_addr, ~req_wdata};
    @(posedge clock) #1;
  endtask
endmodule

/* tb_swb_ctrl.sv */
/* tb_swb_ctrl: scenario bench for swb_ctrl.
   assumes: core model drives requests 1 ns after each edge. */
`timescale 1ns/100ps
module tb_swb_ctrl;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        req, req_write, ready, rd_valid, buf_pending;
  logic [1:0]  req_size;
  logic [13:0] req_addr;
  logic [31:0] req_wdata, rd_data, got;
  int          n_fail = 0;
  int          checks_done = 0;
  always #2.5 clock = ~clock;
  swb_core_model core (.*);
  swb_ctrl uut (.*);
  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // word read with a bounded wait for the answer
  task automatic rd(input logic [13:0] a);
    core.issue(1'b0, 2'h2, a, 32'h0);
    core.idle();
    for (int i = 0; i < 4 && rd_valid !== 1'b1; i++) @(posedge clock) #1;
    if (rd_valid !== 1'b1) begin
      n_fail++;
      finish_test();
    end else begin
      got = rd_data;
    end
  endtask
  task automatic do_reset(input int n);
    rst = 1'b1;
    repeat (n) @(posedge clock);
    #1 rst = 1'b0;
  endtask
  // sub-word writes land on their lanes, merged over the array
  task automatic lanes_test();
    core.issue(1'b1, 2'h2, 14'h0008, 32'h1122_3344);
    core.issue(1'b1, 2'h0, 14'h0009, 32'h0000_00AA);
    rd(14'h0008);
    chk("byte", got, 32'h1122_AA44);
    core.issue(1'b1, 2'h1, 14'h000A, 32'h0000_BEEF);
    rd(14'h0008);
    chk("half", got, 32'hBEEF_AA44);
    core.issue(1'b1, 2'h3, 14'h000C, 32'h7777_8888);
    rd(14'h000C);
    chk("size3", got, 32'h7777_8888);
  endtask
  // commit only on a later write; reset drops the pending entry
  task automatic reset_test();
    core.issue(1'b1, 2'h2, 14'h0010, 32'hCAFE_0001);
    core.issue(1'b1, 2'h2, 14'h0014, 32'h0BAD_F00D);
    core.issue(1'b1, 2'h2, 14'h0010, 32'hCAFE_0002);
    rd(14'h0010);
    chk("hit", got, 32'hCAFE_0002);
    core.issue(1'b1, 2'h2, 14'h0018, 32'h5A5A_0003);
    core.issue(1'b1, 2'h2, 14'h0018, 32'h5A5A_0003);
    core.issue(1'b1, 2'h2, 14'h0010, 32'hDEAD_0004);
    rd(14'h0010);
    chk("pend", buf_pending, 32'h1);
    do_reset(3);
    chk("clear", buf_pending, 32'h0);
    rd(14'h0010);
    chk("lost", got, 32'hCAFE_0002);
    chk("ready", ready, 32'h1);
    rd(14'h0018);
    chk("twice", got, 32'h5A5A_0003);
    rd(14'h0014);
    chk("dummy", got, 32'h0BAD_F00D);
  endtask
  initial begin
    do_reset(5);
    lanes_test();
    reset_test();
    finish_test();
  end
endmodule
